// ---- inc/upm_pkg.sv ----
package upm_pkg;

  // ----------------------------------------------------------------
  // Uplink bus type codes
  // ----------------------------------------------------------------
  localparam logic [1:0] BT_MII = 2'h0;
  localparam logic [1:0] BT_SERIAL = 2'h1;
  localparam logic [1:0] BT_RMII = 2'h2;
  localparam logic [1:0] BT_RESV = 2'h3;

  // ----------------------------------------------------------------
  // Strap pin positions on the shared pin vector
  // ----------------------------------------------------------------
  localparam int STRAP_PAUSE = 0;
  localparam int STRAP_MODE0 = 1;
  localparam int STRAP_MODE1 = 2;
  localparam int NUM_STRAPS = 3;

  // Transmit pin layout: [3:0] data, [4] transmit enable
  localparam int PIN_TXEN = 4;
  localparam int NUM_PINS = 5;
  localparam int NIBBLE_W = 4;

  // Pins driven in each mode
  localparam logic [4:0] OE_MII = 5'h1f;
  localparam logic [4:0] OE_SERIAL = 5'h11;
  localparam logic [4:0] OE_RMII = 5'h13;
  localparam logic [4:0] OE_NONE = 5'h00;

  // Beats per nibble and bits shifted per beat
  localparam logic [2:0] BEATS_MII = 3'h1;
  localparam logic [2:0] BEATS_SERIAL = 3'h4;
  localparam logic [2:0] BEATS_RMII = 3'h2;
  localparam logic [2:0] STEP_MII = 3'h4;
  localparam logic [2:0] STEP_SERIAL = 3'h1;
  localparam logic [2:0] STEP_RMII = 3'h2;

  // Link clock inputs, indexed by bus type code
  localparam int NUM_LCLK = 3;

  // Reset values
  localparam logic RST_PAUSE = 1'b0;
  localparam logic [1:0] RST_BUS_TYPE = BT_MII;

  // Link state, one-hot
  typedef enum logic [2:0] {
    ST_HOLD = 3'h1,
    ST_RUN = 3'h2,
    ST_BAD = 3'h4
  } upm_link_state_t;

endpackage

// ---- rtl/upm_nibble_buf.sv ----
`timescale 1ns/1ps

module upm_nibble_buf #(
  parameter int WIDTH = 4,
  parameter int DEPTH = 2
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic [WIDTH-1:0] in_data_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  output logic [WIDTH-1:0] out_data_o,
  output logic out_valid_o,
  input wire logic out_ready_i
);

  localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CNT_W = $clog2(DEPTH + 1);
  localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(DEPTH);
  localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(DEPTH - 1);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PTR_W-1:0] wr_ptr_q;
  logic [PTR_W-1:0] rd_ptr_q;
  logic [CNT_W-1:0] count_q;
  logic [CNT_W-1:0] count_d;
  logic ready_q;
  logic push_w;
  logic pop_w;

  // Ready is registered from the next count, so it looks one cycle ahead
  assign push_w = in_valid_i && ready_q;
  assign pop_w = out_valid_o && out_ready_i;
  assign out_valid_o = (count_q != '0);
  assign out_data_o = mem_q[rd_ptr_q];
  assign in_ready_o = ready_q;

  always_comb begin
    count_d = count_q;
    if (push_w && !pop_w) begin
      count_d = count_q + 1'b1;
    end else if (pop_w && !push_w) begin
      count_d = count_q - 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      count_q <= '0;
      ready_q <= 1'b0;
    end else begin
      count_q <= count_d;
      ready_q <= (count_d < CNT_FULL);
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      wr_ptr_q <= '0;
    end else if (push_w) begin
      wr_ptr_q <= (wr_ptr_q == PTR_LAST) ? '0 : wr_ptr_q + 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (push_w) begin
      mem_q[wr_ptr_q] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      rd_ptr_q <= '0;
    end else if (pop_w) begin
      rd_ptr_q <= (rd_ptr_q == PTR_LAST) ? '0 : rd_ptr_q + 1'b1;
    end
  end

endmodule // upm_nibble_buf

// ---- rtl/upm_uplink_mux.sv ----
`timescale 1ns/1ps

module upm_uplink_mux import upm_pkg::*; #(
  parameter int PORTS = 6
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic chip_reset_low_i,
  input wire logic [NUM_STRAPS-1:0] strap_pin_i,
  input wire logic mii_tx_clock_i,
  input wire logic serial_tx_clock_i,
  input wire logic rmii_ref_clock_in_i,
  input wire logic [PORTS-1:0] port_pause_cfg_i,
  input wire logic [NIBBLE_W-1:0] tx_data_i,
  input wire logic tx_valid_i,
  output logic tx_ready_o,
  output logic [NUM_PINS-1:0] pin_o,
  output logic [NUM_PINS-1:0] pin_oe_o,
  output logic [PORTS-1:0] port_pause_en_o,
  output logic global_pause_strap_o,
  output logic [1:0] uplink_bus_type_o,
  output logic link_up_o,
  output logic bus_type_bad_o
);

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  localparam int NUM_ASYNC = 1 + NUM_STRAPS + NUM_LCLK;
  localparam int IDX_RST = 0;
  localparam int IDX_STRAP = 1;
  localparam int IDX_LCLK = 1 + NUM_STRAPS;

  logic [NUM_ASYNC-1:0] async_w;
  logic [NUM_ASYNC-1:0] meta_q;
  logic [NUM_ASYNC-1:0] sync_q;

  assign async_w = {rmii_ref_clock_in_i, serial_tx_clock_i,
                    mii_tx_clock_i, strap_pin_i, chip_reset_low_i};

  for (genvar g = 0; g < NUM_ASYNC; g++) begin : g_sync
    always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
        meta_q[g] <= 1'b0;
        sync_q[g] <= 1'b0;
      end else begin
        meta_q[g] <= async_w[g];
        sync_q[g] <= meta_q[g];
      end
    end
  end

  logic chip_rst_n_w;
  logic [NUM_STRAPS-1:0] strap_w;
  logic [NUM_LCLK-1:0] lclk_w;

  assign chip_rst_n_w = sync_q[IDX_RST];
  assign strap_w = sync_q[IDX_STRAP +: NUM_STRAPS];
  assign lclk_w = sync_q[IDX_LCLK +: NUM_LCLK];

  // ----------------------------------------------------------------
  // Strap capture
  // ----------------------------------------------------------------
  logic chip_rst_n_prev_q;
  logic strap_rise_w;
  logic pause_q;
  logic [1:0] bus_type_q;
  logic [1:0] strap_mode_w;

  // Prev resets low so a chip reset already released still latches
  assign strap_rise_w = chip_rst_n_w && !chip_rst_n_prev_q;
  assign strap_mode_w = {strap_w[STRAP_MODE1], strap_w[STRAP_MODE0]};

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      chip_rst_n_prev_q <= 1'b0;
    end else begin
      chip_rst_n_prev_q <= chip_rst_n_w;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      pause_q <= RST_PAUSE;
      bus_type_q <= RST_BUS_TYPE;
    end else if (strap_rise_w) begin
      pause_q <= strap_w[STRAP_PAUSE];
      bus_type_q <= strap_mode_w;
    end
  end

  // ----------------------------------------------------------------
  // Link state
  // ----------------------------------------------------------------
  upm_link_state_t state_q;

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      state_q <= ST_HOLD;
    end else begin
      case (state_q)
        ST_HOLD: begin
          if (strap_rise_w) begin
            // Reserved code leaves every pin undriven
            state_q <= (strap_mode_w == BT_RESV) ? ST_BAD : ST_RUN;
          end
        end
        ST_RUN, ST_BAD: begin
          if (!chip_rst_n_w) begin
            state_q <= ST_HOLD;
          end
        end
        default: begin
          state_q <= ST_HOLD;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Flow-control enables
  // ----------------------------------------------------------------
  logic [PORTS-1:0] pause_en_q;

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      pause_en_q <= '0;
    end else if (pause_q) begin
      pause_en_q <= '1;
    end else begin
      pause_en_q <= port_pause_cfg_i;
    end
  end

  // ----------------------------------------------------------------
  // Link clock edge of the selected interface
  // ----------------------------------------------------------------
  logic sel_clk_w;
  logic sel_clk_prev_q;
  logic run_w;
  logic link_edge_w;

  assign run_w = (state_q == ST_RUN);
  assign sel_clk_w = (bus_type_q == BT_RESV) ? 1'b0 : lclk_w[bus_type_q];
  assign link_edge_w = run_w && sel_clk_w && !sel_clk_prev_q;

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      sel_clk_prev_q <= 1'b0;
    end else begin
      sel_clk_prev_q <= sel_clk_w;
    end
  end

  // ----------------------------------------------------------------
  // Two-entry buffer in the data path
  // ----------------------------------------------------------------
  logic [NIBBLE_W-1:0] buf_data_w;
  logic buf_valid_w;
  logic pop_w;

  upm_nibble_buf #(
    .WIDTH(NIBBLE_W),
    .DEPTH(2)
  ) u_buf (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .in_data_i(tx_data_i),
    .in_valid_i(tx_valid_i),
    .in_ready_o(tx_ready_o),
    .out_data_o(buf_data_w),
    .out_valid_o(buf_valid_w),
    .out_ready_i(pop_w)
  );

  // ----------------------------------------------------------------
  // Serialiser: one nibble per MII beat, two RMII, four serial
  // ----------------------------------------------------------------
  logic [NIBBLE_W-1:0] shift_q;
  logic [NIBBLE_W-1:0] shift_next_w;
  logic [2:0] beats_q;
  logic [2:0] beats_mode_w;
  logic [2:0] step_w;
  logic [NUM_PINS-1:0] pin_q;
  logic [NUM_PINS-1:0] oe_q;
  logic [NUM_PINS-1:0] oe_mode_w;
  logic [NIBBLE_W-1:0] data_mask_w;

  always_comb begin
    case (bus_type_q)
      BT_MII: begin
        beats_mode_w = BEATS_MII;
        step_w = STEP_MII;
        oe_mode_w = OE_MII;
      end
      BT_SERIAL: begin
        beats_mode_w = BEATS_SERIAL;
        step_w = STEP_SERIAL;
        oe_mode_w = OE_SERIAL;
      end
      BT_RMII: begin
        beats_mode_w = BEATS_RMII;
        step_w = STEP_RMII;
        oe_mode_w = OE_RMII;
      end
      default: begin
        beats_mode_w = BEATS_MII;
        step_w = STEP_MII;
        oe_mode_w = OE_NONE;
      end
    endcase
  end

  assign data_mask_w = oe_mode_w[NIBBLE_W-1:0];
  assign shift_next_w = shift_q >> step_w;
  // A new nibble is taken only once the last beat of the old one is out
  assign pop_w = link_edge_w && (beats_q <= 3'h1) && buf_valid_w;

  always_ff @(posedge clk_i) begin
    if (sys_rst_i || !run_w) begin
      shift_q <= '0;
      beats_q <= '0;
      pin_q <= '0;
    end else if (link_edge_w) begin
      if (beats_q > 3'h1) begin
        shift_q <= shift_next_w;
        beats_q <= beats_q - 3'h1;
        pin_q[NIBBLE_W-1:0] <= shift_next_w & data_mask_w;
        pin_q[PIN_TXEN] <= 1'b1;
      end else if (buf_valid_w) begin
        shift_q <= buf_data_w;
        beats_q <= beats_mode_w;
        // MII takes the nibble whole, RMII its low dibit, serial bit 0
        pin_q[NIBBLE_W-1:0] <= buf_data_w
                               & data_mask_w;
        pin_q[PIN_TXEN] <= 1'b1;
      end else begin
        beats_q <= '0;
        pin_q <= '0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      oe_q <= OE_NONE;
    end else begin
      oe_q <= run_w ? oe_mode_w : OE_NONE;
    end
  end

  // ----------------------------------------------------------------
  // Status outputs
  // ----------------------------------------------------------------
  logic link_up_q;
  logic bad_q;

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      link_up_q <= 1'b0;
      bad_q <= 1'b0;
    end else begin
      link_up_q <= run_w;
      bad_q <= (state_q == ST_BAD);
    end
  end

  assign pin_o = pin_q;
  assign pin_oe_o = oe_q;
  assign port_pause_en_o = pause_en_q;
  assign global_pause_strap_o = pause_q;
  assign uplink_bus_type_o = bus_type_q;
  assign link_up_o = link_up_q;
  assign bus_type_bad_o = bad_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_pause_hold: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    !strap_rise_w |=> $stable(pause_q))
    else $error("pause strap changed without reset rise");

  a_pause_percfg: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    !pause_q |=> (pause_q || port_pause_en_o == $past(port_pause_cfg_i)))
    else $error("pause enables do not follow configuration");

  a_pause_all: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    pause_q ##1 pause_q |-> port_pause_en_o == '1)
    else $error("pause not enabled on all ports");

  a_mode_latch: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    strap_rise_w |=> bus_type_q == $past(strap_mode_w)
                     && pause_q == $past(strap_w[STRAP_PAUSE]))
    else $error("straps not latched at reset rise");

  a_mode_stable: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    !strap_rise_w |=> $stable(bus_type_q))
    else $error("bus type changed without reset rise");

  a_resv_quiet: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    bus_type_q == BT_RESV |-> !run_w ##1 pin_oe_o == OE_NONE)
    else $error("reserved bus type drives pins");

  a_mii_timing: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    run_w && bus_type_q == BT_MII && $changed(pin_q[1:0])
      |-> $past(link_edge_w))
    else $error("MII data moved off the clock edge");

  a_serial_timing: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    run_w && bus_type_q == BT_SERIAL && $changed(pin_q[0])
      |-> $past(link_edge_w) && pin_q[3:1] == 3'h0)
    else $error("serial line moved off the clock edge");

  a_rmii_timing: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    run_w && bus_type_q == BT_RMII && $changed(pin_q[1:0])
      |-> $past(link_edge_w) && pin_q[3:2] == 2'h0)
    else $error("RMII data moved off the reference edge");

  a_mii_enable: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    run_w && bus_type_q == BT_MII && pop_w
      |=> pin_q[PIN_TXEN] && pin_q[3:0] == $past(buf_data_w))
    else $error("MII enable or data wrong after load");

  a_mii_idle: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    run_w && bus_type_q == BT_MII && link_edge_w && !buf_valid_w
      |=> !pin_q[PIN_TXEN])
    else $error("MII enable high with no data");

  a_hold_input: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    !run_w |=> pin_oe_o == OE_NONE)
    else $error("pins driven while not running");

endmodule // upm_uplink_mux

// ---- tb/tb.sv ----
`timescale 1ns/1ps

module tb import upm_pkg::*;;
  logic clk_i, sys_rst_i, chip_reset_low_i, tx_valid_i, tx_ready_o;
  logic [NUM_STRAPS-1:0] strap_pin_i;
  logic [5:0] port_pause_cfg_i, port_pause_en_o;
  logic [NIBBLE_W-1:0] tx_data_i;
  logic [NUM_PINS-1:0] pin_o, pin_oe_o;
  logic global_pause_strap_o, link_up_o, bus_type_bad_o;
  logic [1:0] uplink_bus_type_o;
  logic mii_clk, ser_clk, rmii_clk;
  logic [NUM_LCLK-1:0] clk_en;
  int err_total = 0;
  int comparisons = 0;

  upm_uplink_mux #(.PORTS(6)) i_dut (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .chip_reset_low_i(chip_reset_low_i), .strap_pin_i(strap_pin_i),
    .mii_tx_clock_i(mii_clk), .serial_tx_clock_i(ser_clk),
    .rmii_ref_clock_in_i(rmii_clk), .port_pause_cfg_i(port_pause_cfg_i),
    .tx_data_i(tx_data_i), .tx_valid_i(tx_valid_i),
    .tx_ready_o(tx_ready_o), .pin_o(pin_o), .pin_oe_o(pin_oe_o),
    .port_pause_en_o(port_pause_en_o),
    .global_pause_strap_o(global_pause_strap_o),
    .uplink_bus_type_o(uplink_bus_type_o), .link_up_o(link_up_o),
    .bus_type_bad_o(bus_type_bad_o));

  upm_phy_model i_phy (
    .clk_en_i(clk_en), .pin_i(pin_o), .mii_tx_clock_o(mii_clk),
    .serial_tx_clock_o(ser_clk), .rmii_ref_clock_o(rmii_clk));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic test_done();
    if (err_total == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] exp,
                     input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic push(input logic [3:0] n);
    int w;
    @(negedge clk_i);
    tx_valid_i = 1'b1;
    tx_data_i = n;
    w = 0;
    @(posedge clk_i);
    while (tx_ready_o !== 1'b1 && w < 4000) begin
      @(posedge clk_i);
      w++;
    end
    chk("tx_ready", 8'h01, {7'h0, tx_ready_o});
  endtask

  task automatic chip_reset(input logic [2:0] s);
    @(negedge clk_i);
    chip_reset_low_i = 1'b0;
    strap_pin_i = s;
    repeat (6) @(negedge clk_i);
    chk("oe_in_reset", OE_NONE, pin_oe_o);
    chip_reset_low_i = 1'b1;
    repeat (8) @(negedge clk_i);
    // Pins now belong to the transmitter; show a different level
    strap_pin_i = ~s;
    repeat (4) @(negedge clk_i);
    chk("pause_strap", s[0], global_pause_strap_o);
    chk("bus_type", s[2:1], uplink_bus_type_o);
  endtask

  task automatic pause_check(input logic p);
    for (int i = 0; i < 2; i++) begin
      port_pause_cfg_i = i ? 6'h12 : 6'h2d;
      repeat (3) @(negedge clk_i);
      chk("pause_en", p ? 6'h3f : port_pause_cfg_i,
          port_pause_en_o);
    end
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic run_mode(input logic [2:0] s, input logic p);
    logic [NUM_PINS-1:0] exp[$];
    logic [1:0] bt;
    logic [3:0] nib[5];
    int w;
    nib = '{4'h9, 4'h6, 4'h0, 4'hf, 4'h5};
    bt = s[2:1];
    chip_reset(s);
    pause_check(p);
    chk("oe", bt == BT_MII ? OE_MII : bt == BT_SERIAL ? OE_SERIAL :
        OE_RMII, pin_oe_o);
    chk("link_up", 8'h01, link_up_o);
    chk("bad", 8'h00, bus_type_bad_o);
    // Link clock stopped: the buffer must fill and refuse the third
    push(nib[0]);
    push(nib[1]);
    @(negedge clk_i);
    tx_data_i = nib[2];
    repeat (20) @(negedge clk_i);
    chk("ready_full", 8'h00, tx_ready_o);
    clk_en[bt] = 1'b1;
    for (int i = 2; i < 5; i++) begin
      push(nib[i]);
    end
    @(negedge clk_i);
    tx_valid_i = 1'b0;
    foreach (nib[i]) begin
      case (bt)
        BT_MII: exp.push_back({1'b1, nib[i]});
        BT_RMII: begin
          exp.push_back({3'h4, nib[i][1:0]});
          exp.push_back({3'h4, nib[i][3:2]});
        end
        default: begin
          for (int b = 0; b < 4; b++) begin
            exp.push_back({4'h8, nib[i][b]});
          end
        end
      endcase
    end
    w = 0;
    while (i_phy.beats.size() < exp.size() && w < 8000) begin
      @(negedge clk_i);
      w++;
    end
    repeat (48) @(negedge clk_i);
    chk("pin_idle", 8'h00, pin_o);
    clk_en = '0;
    chk("beat_count", 8'(exp.size()), 8'(i_phy.beats.size()));
    foreach (exp[k]) begin
      if (k < i_phy.beats.size()) begin
        chk("beat", exp[k], i_phy.beats[k]);
      end
    end
    i_phy.beats.delete();
  endtask

  task automatic reserved_code();
    chip_reset(3'b110);
    chk("bad", 8'h01, bus_type_bad_o);
    chk("oe", OE_NONE, pin_oe_o);
    chk("link_up", 8'h00, link_up_o);
    clk_en = 3'h7;
    repeat (64) @(negedge clk_i);
    chk("pin_txen", 8'h00, pin_o[PIN_TXEN]);
    clk_en = '0;
  endtask

  // ----------------------------------------------------------------
  // Clock, sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  initial begin
    sys_rst_i = 1'b1;
    chip_reset_low_i = 1'b0;
    strap_pin_i = 3'h0;
    port_pause_cfg_i = 6'h00;
    tx_data_i = 4'h0;
    tx_valid_i = 1'b0;
    clk_en = '0;
    repeat (16) @(negedge clk_i);
    sys_rst_i = 1'b0;
    repeat (2) @(negedge clk_i);
    run_mode(3'b001, 1'b1);
    run_mode(3'b010, 1'b0);
    run_mode(3'b100, 1'b0);
    run_mode(3'b101, 1'b1);
    reserved_code();
    test_done();
  end

  // Whole run needs roughly 5 us; allow twenty times that
  initial begin
    #100000;
    err_total++;
    test_done();
  end
endmodule // tb

// ---- tb/upm_phy_model.sv ----
`timescale 1ns/1ps

// ----------------------------------------------------------------
// Far-side transceiver: makes the link clocks, samples the pins
// ----------------------------------------------------------------
module upm_phy_model import upm_pkg::*; (
  input wire logic [NUM_LCLK-1:0] clk_en_i,
  input wire logic [NUM_PINS-1:0] pin_i,
  output logic mii_tx_clock_o,
  output logic serial_tx_clock_o,
  output logic rmii_ref_clock_o
);
  logic free_clk = 1'b0;
  logic [NUM_LCLK-1:0] en_q = '0;
  logic sel_clk;
  logic [NUM_PINS-1:0] beats[$];

  // Odd offset keeps the link clock out of phase with the system clock
  initial begin
    #1.3;
    forever #32 free_clk = ~free_clk;
  end

  // Gate only while low, so a stopped clock never leaves a runt pulse
  always @(negedge free_clk) begin
    en_q <= clk_en_i;
  end

  assign mii_tx_clock_o = free_clk & en_q[0];
  assign serial_tx_clock_o = free_clk & en_q[1];
  assign rmii_ref_clock_o = free_clk & en_q[2];
  assign sel_clk = mii_tx_clock_o | serial_tx_clock_o | rmii_ref_clock_o;

  // Receiver takes a beat at each rising link edge while enable is high
  always @(posedge sel_clk) begin
    if (pin_i[PIN_TXEN]) begin
      beats.push_back(pin_i);
    end
  end
endmodule // upm_phy_model
